/* File: rtl/sru_return_unit.sv */
// return-class instruction execution unit with its APB register file
//
// Design decisions made here: the APB slave port and the address map.
module sru_return_unit (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sru_pkg::ADDR_W-1:0] paddr,
  input wire logic [sru_pkg::DATA_W-1:0] pwdata,
  output logic [sru_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr
);
  import sru_pkg::*;

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  sru_stack_if stk ();

  sru_state_type state_reg, state_next;
  sru_op_type op_reg, op_next;
  logic restore_reg, restore_next;
  logic [INSTR_W-1:0] instr_reg, instr_next;
  logic [PC_W-1:0] pc_reg, pc_next;
  logic [ACC_W-1:0] acc_reg, acc_next;
  logic [FLAG_W-1:0] flags_reg, flags_next;
  logic [BANK_W-1:0] bank_select_reg, bank_select_next;
  logic [ACC_W-1:0] accumulator_shadow_reg, accumulator_shadow_next;
  logic [FLAG_W-1:0] flags_shadow_reg, flags_shadow_next;
  logic [BANK_W-1:0] bank_select_shadow_reg, bank_select_shadow_next;
  logic [ACC_W-1:0] pc_high_latch_reg, pc_high_latch_next;
  logic [ACC_W-1:0] pc_upper_latch_reg, pc_upper_latch_next;
  logic [9:0] irq_ctrl_reg, irq_ctrl_next;
  logic underflow_reg, underflow_next;
  logic [DATA_W-1:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;

  logic access;
  logic write_fire;
  logic mapped;
  logic busy;
  logic opcode_known;
  sru_op_type wr_op;
  logic [DATA_W-1:0] read_word;

  sru_return_stack u_stack (
    .pclk(pclk),
    .presetn(presetn),
    .stk(stk.stack)
  );

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

  // ------------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------------
  assign access = psel && penable;
  assign write_fire = access && pready_reg && pwrite && !pslverr_reg;
  assign busy = (state_reg != ST_IDLE);

  always_comb begin
    wr_op = OP_NONE;
    if (pwdata[INSTR_W-1:1] == OPC_IRQ_RETURN) begin
      wr_op = OP_IRQ_RETURN;
    end else if (pwdata[INSTR_W-1:1] == OPC_SUB_RETURN) begin
      wr_op = OP_SUB_RETURN;
    end else if (pwdata[INSTR_W-1:8] == OPC_LITERAL_RETURN) begin
      wr_op = OP_LITERAL_RETURN;
    end
  end
  assign opcode_known = (wr_op != OP_NONE);

  always_comb begin
    mapped = 1'b1;
    read_word = '0;
    case (paddr)
      OFF_INSTR: read_word = DATA_W'(instr_reg);
      OFF_EXEC_STAT: begin
        read_word[BIT_BUSY] = busy;
        read_word[BIT_UNDERFLOW] = underflow_reg;
        read_word[POS_DEPTH +: DEPTH_W] = stk.depth;
      end
      OFF_PC: read_word = DATA_W'(pc_reg);
      OFF_ACC: read_word = DATA_W'(acc_reg);
      OFF_FLAGS: read_word = DATA_W'(flags_reg);
      OFF_BANK: read_word = DATA_W'(bank_select_reg);
      OFF_ACC_SHADOW: read_word = DATA_W'(accumulator_shadow_reg);
      OFF_FLAGS_SHADOW: read_word = DATA_W'(flags_shadow_reg);
      OFF_BANK_SHADOW: read_word = DATA_W'(bank_select_shadow_reg);
      OFF_PC_HIGH_LATCH: read_word = DATA_W'(pc_high_latch_reg);
      OFF_PC_UPPER_LATCH: read_word = DATA_W'(pc_upper_latch_reg);
      OFF_IRQ_CTRL: read_word = DATA_W'(irq_ctrl_reg);
      OFF_STACK: read_word = DATA_W'(stk.stack_top);
      default: mapped = 1'b0;
    endcase
  end

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    op_next = op_reg;
    restore_next = restore_reg;
    instr_next = instr_reg;
    pc_next = pc_reg;
    acc_next = acc_reg;
    flags_next = flags_reg;
    bank_select_next = bank_select_reg;
    accumulator_shadow_next = accumulator_shadow_reg;
    flags_shadow_next = flags_shadow_reg;
    bank_select_shadow_next = bank_select_shadow_reg;
    // latches only move by a bus write, never refused-free while busy
    pc_high_latch_next = pc_high_latch_reg;
    pc_upper_latch_next = pc_upper_latch_reg;
    irq_ctrl_next = irq_ctrl_reg;
    underflow_next = underflow_reg;
    stk.push = 1'b0;
    stk.pop = 1'b0;
    stk.push_data = pwdata[PC_W-1:0];

    // answer one cycle into the access phase; writes refused while busy
    pready_next = access && !pready_reg;
    prdata_next = prdata_reg;
    pslverr_next = pslverr_reg;
    if (access && !pready_reg) begin
      prdata_next = pwrite ? '0 : read_word;
      pslverr_next = !mapped || (pwrite && busy) ||
                     (pwrite && paddr == OFF_INSTR && !opcode_known);
    end else if (!access) begin
      pslverr_next = 1'b0;
    end

    if (write_fire) begin
      case (paddr)
        OFF_INSTR: begin
          instr_next = pwdata[INSTR_W-1:0];
          op_next = wr_op;
          restore_next = pwdata[0];
          state_next = ST_EXEC;
        end
        OFF_EXEC_STAT: begin
          if (pwdata[BIT_UNDERFLOW]) begin
            underflow_next = 1'b0;
          end
        end
        OFF_PC: pc_next = pwdata[PC_W-1:0];
        OFF_ACC: acc_next = pwdata[ACC_W-1:0];
        OFF_FLAGS: flags_next = pwdata[FLAG_W-1:0];
        OFF_BANK: bank_select_next = pwdata[BANK_W-1:0];
        OFF_ACC_SHADOW: accumulator_shadow_next = pwdata[ACC_W-1:0];
        OFF_FLAGS_SHADOW: flags_shadow_next = pwdata[FLAG_W-1:0];
        OFF_BANK_SHADOW: bank_select_shadow_next = pwdata[BANK_W-1:0];
        OFF_PC_HIGH_LATCH: pc_high_latch_next = pwdata[ACC_W-1:0];
        OFF_PC_UPPER_LATCH: pc_upper_latch_next = pwdata[ACC_W-1:0];
        OFF_IRQ_CTRL: irq_ctrl_next = pwdata[9:0];
        OFF_STACK: stk.push = 1'b1;
        default: ;
      endcase
    end

    case (state_reg)
      ST_IDLE: ;
      ST_EXEC: begin
        // pop, pc load and register restore all land on this one edge
        stk.pop = 1'b1;
        pc_next = stk.stack_top;
        if (stk.empty) begin
          // set wins over a software clear in the same cycle
          underflow_next = 1'b1;
        end
        if (op_reg == OP_LITERAL_RETURN) begin
          acc_next = instr_reg[ACC_W-1:0];
        end else if (restore_reg) begin
          acc_next = accumulator_shadow_reg;
          flags_next = flags_shadow_reg;
          bank_select_next = bank_select_shadow_reg;
        end
        if (op_reg == OP_IRQ_RETURN) begin
          if (irq_ctrl_reg[BIT_PRIORITY_MODE] && irq_ctrl_reg[BIT_LOW_LEVEL_RETURN]) begin
            irq_ctrl_next[BIT_PERIPHERAL_IRQ_ON] = 1'b1;
          end else begin
            irq_ctrl_next[BIT_GLOBAL_IRQ_ON] = 1'b1;
          end
        end
        state_next = ST_NOP;
      end
      // fetch restarts at the new pc; nothing else happens here
      ST_NOP: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      op_reg <= OP_NONE;
      restore_reg <= 1'b0;
      instr_reg <= RST_INSTR;
      pc_reg <= RST_PC;
      acc_reg <= RST_ACC;
      flags_reg <= RST_FLAGS;
      bank_select_reg <= RST_BANK;
      accumulator_shadow_reg <= RST_ACC;
      flags_shadow_reg <= RST_FLAGS;
      bank_select_shadow_reg <= RST_BANK;
      pc_high_latch_reg <= RST_ACC;
      pc_upper_latch_reg <= RST_ACC;
      irq_ctrl_reg <= RST_IRQ_CTRL;
      underflow_reg <= 1'b0;
      prdata_reg <= '0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      op_reg <= op_next;
      restore_reg <= restore_next;
      instr_reg <= instr_next;
      pc_reg <= pc_next;
      acc_reg <= acc_next;
      flags_reg <= flags_next;
      bank_select_reg <= bank_select_next;
      accumulator_shadow_reg <= accumulator_shadow_next;
      flags_shadow_reg <= flags_shadow_next;
      bank_select_shadow_reg <= bank_select_shadow_next;
      pc_high_latch_reg <= pc_high_latch_next;
      pc_upper_latch_reg <= pc_upper_latch_next;
      irq_ctrl_reg <= irq_ctrl_next;
      underflow_reg <= underflow_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_decode_literal: assert property (
    write_fire && paddr == OFF_INSTR && pwdata[15:8] == 8'h0C
    |=> state_reg == ST_EXEC && op_reg == OP_LITERAL_RETURN)
    else $error("literal return opcode not decoded");

  chk_pop_to_pc: assert property (
    state_reg == ST_EXEC && op_reg != OP_LITERAL_RETURN
    |=> pc_reg == $past(stk.stack_top))
    else $error("return did not load pc from stack top");

  chk_irq_enable_set: assert property (
    state_reg == ST_EXEC && op_reg == OP_IRQ_RETURN && !irq_ctrl_reg[BIT_PRIORITY_MODE]
    |=> irq_ctrl_reg[BIT_GLOBAL_IRQ_ON] && $stable(irq_ctrl_reg[BIT_PERIPHERAL_IRQ_ON]) &&
        ($stable(flags_reg) || $past(restore_reg)))
    else $error("irq return did not set the global enable alone");

  chk_irq_level_set: assert property (
    state_reg == ST_EXEC && op_reg == OP_IRQ_RETURN && irq_ctrl_reg[BIT_PRIORITY_MODE]
    |=> $past(irq_ctrl_reg[BIT_LOW_LEVEL_RETURN]) ?
        (irq_ctrl_reg[BIT_PERIPHERAL_IRQ_ON] && $stable(irq_ctrl_reg[BIT_GLOBAL_IRQ_ON])) :
        (irq_ctrl_reg[BIT_GLOBAL_IRQ_ON] && $stable(irq_ctrl_reg[BIT_PERIPHERAL_IRQ_ON])))
    else $error("irq return set the wrong priority level enable");

  chk_shadow_restore: assert property (
    state_reg == ST_EXEC && op_reg != OP_LITERAL_RETURN && restore_reg
    |=> acc_reg == $past(accumulator_shadow_reg) &&
        flags_reg == $past(flags_shadow_reg) &&
        bank_select_reg == $past(bank_select_shadow_reg))
    else $error("shadow copies not restored");

  chk_no_restore: assert property (
    state_reg == ST_EXEC && op_reg != OP_LITERAL_RETURN && !restore_reg
    |=> $stable(acc_reg) && $stable(flags_reg) && $stable(bank_select_reg))
    else $error("working registers changed without restore");

  chk_literal_acc: assert property (
    state_reg == ST_EXEC && op_reg == OP_LITERAL_RETURN
    |=> acc_reg == $past(instr_reg[7:0]) && pc_reg == $past(stk.stack_top))
    else $error("literal return wrong accumulator or pc");

  chk_latches_hold: assert property (
    state_reg != ST_IDLE
    |=> $stable(pc_high_latch_reg) && $stable(pc_upper_latch_reg))
    else $error("pc latches changed during a return");

  chk_pop_depth: assert property (
    state_reg == ST_EXEC && !stk.empty
    |=> stk.depth == $past(stk.depth) - 5'h01)
    else $error("pop did not drop the stack depth");

  chk_two_cycles: assert property (
    $rose(busy) |-> state_reg == ST_EXEC ##1 state_reg == ST_NOP ##1 !busy)
    else $error("return did not take exactly two cycles");

  // no bus write can land here, so any change means the no-op cycle acted
  chk_nop_quiet: assert property (
    state_reg == ST_NOP
    |=> $stable(pc_reg) && $stable(acc_reg) && $stable(flags_reg) && $stable(stk.depth))
    else $error("second return cycle was not a no-op");
endmodule

/* File: rtl/sru_pkg.sv */
// package: constants, offsets and types of the subroutine return unit
package sru_pkg;
  // ------------------------------------------------------------------
  // widths
  // ------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int PC_W = 21;
  localparam int ACC_W = 8;
  localparam int FLAG_W = 5;
  localparam int BANK_W = 4;
  localparam int INSTR_W = 16;
  localparam int STACK_DEPTH = 31;
  localparam int DEPTH_W = 5;

  // ------------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_INSTR = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_EXEC_STAT = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_PC = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_ACC = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_FLAGS = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_BANK = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_ACC_SHADOW = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_FLAGS_SHADOW = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_BANK_SHADOW = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_PC_HIGH_LATCH = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_PC_UPPER_LATCH = 8'h28;
  localparam logic [ADDR_W-1:0] OFF_IRQ_CTRL = 8'h2C;
  localparam logic [ADDR_W-1:0] OFF_STACK = 8'h30;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int BIT_BUSY = 0;
  localparam int BIT_UNDERFLOW = 1;
  localparam int POS_DEPTH = 8;
  localparam int BIT_GLOBAL_IRQ_ON = 7;
  localparam int BIT_PERIPHERAL_IRQ_ON = 6;
  localparam int BIT_PRIORITY_MODE = 8;
  localparam int BIT_LOW_LEVEL_RETURN = 9;

  // ------------------------------------------------------------------
  // opcode patterns
  // ------------------------------------------------------------------
  localparam logic [INSTR_W-2:0] OPC_IRQ_RETURN = 15'h0008;
  localparam logic [INSTR_W-2:0] OPC_SUB_RETURN = 15'h0009;
  localparam logic [7:0] OPC_LITERAL_RETURN = 8'h0C;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [PC_W-1:0] RST_PC = 21'h000000;
  localparam logic [ACC_W-1:0] RST_ACC = 8'h00;
  localparam logic [FLAG_W-1:0] RST_FLAGS = 5'h00;
  localparam logic [BANK_W-1:0] RST_BANK = 4'h0;
  localparam logic [INSTR_W-1:0] RST_INSTR = 16'h0000;
  localparam logic [9:0] RST_IRQ_CTRL = 10'h000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_NOP = 2'b10
  } sru_state_type;

  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_IRQ_RETURN = 2'b01,
    OP_SUB_RETURN = 2'b10,
    OP_LITERAL_RETURN = 2'b11
  } sru_op_type;
endpackage

/* File: rtl/sru_stack_if.sv */
// interface between the unit and its return stack
interface sru_stack_if;
  import sru_pkg::*;
  logic push;
  logic pop;
  logic [PC_W-1:0] push_data;
  logic [PC_W-1:0] stack_top;
  logic [DEPTH_W-1:0] depth;
  logic empty;
  logic full;
  modport owner (output push, output pop, output push_data,
                 input stack_top, input depth, input empty, input full);
  modport stack (input push, input pop, input push_data,
                 output stack_top, output depth, output empty, output full);
endinterface

/* File: rtl/sru_return_stack.sv */
// hardware return stack with top-of-stack view
module sru_return_stack (
  input wire logic pclk,
  input wire logic presetn,
  sru_stack_if.stack stk
);
  import sru_pkg::*;

  logic [PC_W-1:0] mem [STACK_DEPTH];
  logic [DEPTH_W-1:0] depth_reg;
  logic [DEPTH_W-1:0] depth_next;

  assign stk.empty = (depth_reg == '0);
  assign stk.full = (depth_reg == DEPTH_W'(STACK_DEPTH));
  assign stk.depth = depth_reg;
  // empty stack shows zero so a stray pop returns to address zero
  assign stk.stack_top = stk.empty ? '0 : mem[depth_reg - 5'h01];

  always_comb begin
    depth_next = depth_reg;
    if (stk.pop && !stk.empty) begin
      depth_next = depth_reg - 5'h01;
    end else if (stk.push && !stk.full) begin
      depth_next = depth_reg + 5'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      depth_reg <= '0;
    end else begin
      depth_reg <= depth_next;
    end
  end

  // storage needs no reset; entries above the depth are never read
  always_ff @(posedge pclk) begin
    if (stk.push && !stk.pop && !stk.full) begin
      mem[depth_reg] <= stk.push_data;
    end
  end
endmodule

/* File: verification/sru_return_unit_tb.sv */
// self-checking bench for the return-class instruction unit over its register bus
module sru_return_unit_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import sru_pkg::*;

  // ------------------------------------------------------------------
  // signals and design
  // ------------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [DATA_W-1:0] pwdata = 32'h00000000;
  logic [DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  int mismatches = 0;
  int checked = 0;

  sru_return_unit i_sru_return_unit (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr)
  );

  initial begin
    forever #5 pclk = ~pclk;
  end

  // ------------------------------------------------------------------
  // bus tasks
  // ------------------------------------------------------------------
  task automatic finish_test();
    if (mismatches == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one idle edge before each setup so psel never gets two assignments in a step
  task automatic xfer(input logic wr_en, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic er);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      mismatches++;
      $display("MISMATCH pready expected 1 seen timeout");
      finish_test();
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic exp_err);
    logic [31:0] rd;
    logic er;
    xfer(1'b1, a, d, rd, er);
    chk("pslverr", {31'h0, exp_err}, {31'h0, er});
  endtask

  task automatic rdc(input string name, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic er;
    xfer(1'b0, a, 32'h00000000, rd, er);
    chk(name, exp, rd);
  endtask

  // executes one opcode and waits, bounded, until the unit is idle again
  task automatic exec(input logic [15:0] op);
    logic [31:0] rd;
    logic er;
    int n;
    wr(OFF_INSTR, {16'h0000, op}, 1'b0);
    n = 0;
    do begin
      xfer(1'b0, OFF_EXEC_STAT, 32'h00000000, rd, er);
      n++;
    end while (rd[BIT_BUSY] !== 1'b0 && n < 10);
    chk("busy", 32'h00000000, {31'h0, rd[BIT_BUSY]});
  endtask

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  logic [7:0] lits [2] = '{8'h00, 8'hFF};

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdc("pc", OFF_PC, 32'h00000000);
    rdc("irq_ctrl", OFF_IRQ_CTRL, 32'h00000000);
    rdc("stack_top", OFF_STACK, 32'h00000000);
    // three return addresses, top holds the last one
    wr(OFF_STACK, 32'h00012346, 1'b0);
    wr(OFF_STACK, 32'h000155AA, 1'b0);
    wr(OFF_STACK, 32'h001F0F0F, 1'b0);
    wr(OFF_ACC_SHADOW, 32'h000000A5, 1'b0);
    wr(OFF_FLAGS_SHADOW, 32'h00000015, 1'b0);
    wr(OFF_BANK_SHADOW, 32'h00000009, 1'b0);
    wr(OFF_ACC, 32'h00000011, 1'b0);
    wr(OFF_FLAGS, 32'h00000002, 1'b0);
    wr(OFF_BANK, 32'h00000003, 1'b0);
    wr(OFF_PC_HIGH_LATCH, 32'h0000005A, 1'b0);
    wr(OFF_PC_UPPER_LATCH, 32'h0000003C, 1'b0);
    // plain subroutine return, no restore
    exec(16'h0012);
    rdc("pc", OFF_PC, 32'h001F0F0F);
    rdc("stack_top", OFF_STACK, 32'h000155AA);
    rdc("exec_stat", OFF_EXEC_STAT, 32'h00000200);
    rdc("acc", OFF_ACC, 32'h00000011);
    rdc("flags", OFF_FLAGS, 32'h00000002);
    rdc("bank", OFF_BANK, 32'h00000003);
    rdc("irq_ctrl", OFF_IRQ_CTRL, 32'h00000000);
    // interrupt return with restore
    exec(16'h0011);
    rdc("pc", OFF_PC, 32'h000155AA);
    rdc("stack_top", OFF_STACK, 32'h00012346);
    rdc("acc", OFF_ACC, 32'h000000A5);
    rdc("flags", OFF_FLAGS, 32'h00000015);
    rdc("bank", OFF_BANK, 32'h00000009);
    rdc("irq_ctrl", OFF_IRQ_CTRL, 32'h00000080);
    // literal return, both ends of the literal range
    exec(16'h0CFF);
    rdc("acc", OFF_ACC, 32'h000000FF);
    rdc("pc", OFF_PC, 32'h00012346);
    rdc("flags", OFF_FLAGS, 32'h00000015);
    rdc("stack_top", OFF_STACK, 32'h00000000);
    foreach (lits[i]) begin
      wr(OFF_STACK, 32'h00000400 + i, 1'b0);
      exec({8'h0C, lits[i]});
      rdc("acc", OFF_ACC, {24'h0, lits[i]});
      rdc("pc", OFF_PC, 32'h00000400 + i);
    end
    rdc("pc_high_latch", OFF_PC_HIGH_LATCH, 32'h0000005A);
    rdc("pc_upper_latch", OFF_PC_UPPER_LATCH, 32'h0000003C);
    // priority levels: low then high enable, flags left alone
    wr(OFF_FLAGS, 32'h0000000A, 1'b0);
    wr(OFF_IRQ_CTRL, 32'h00000300, 1'b0);
    wr(OFF_STACK, 32'h00000800, 1'b0);
    exec(16'h0010);
    rdc("irq_ctrl", OFF_IRQ_CTRL, 32'h00000340);
    rdc("flags", OFF_FLAGS, 32'h0000000A);
    wr(OFF_IRQ_CTRL, 32'h00000100, 1'b0);
    wr(OFF_STACK, 32'h00000900, 1'b0);
    exec(16'h0010);
    rdc("irq_ctrl", OFF_IRQ_CTRL, 32'h00000180);
    rdc("pc", OFF_PC, 32'h00000900);
    // subroutine return with restore
    wr(OFF_ACC, 32'h00000033, 1'b0);
    wr(OFF_STACK, 32'h00000A00, 1'b0);
    exec(16'h0013);
    rdc("acc", OFF_ACC, 32'h000000A5);
    rdc("flags", OFF_FLAGS, 32'h00000015);
    rdc("bank", OFF_BANK, 32'h00000009);
    rdc("pc", OFF_PC, 32'h00000A00);
    // refusals: non-return opcode, unmapped and misaligned places
    wr(OFF_INSTR, 32'h00000014, 1'b1);
    wr(8'h40, 32'h00000001, 1'b1);
    wr(8'h02, 32'h00000001, 1'b1);
    rdc("pc", OFF_PC, 32'h00000A00);
    // pop of an empty stack sets the sticky underflow bit
    exec(16'h0012);
    rdc("pc", OFF_PC, 32'h00000000);
    rdc("exec_stat", OFF_EXEC_STAT, 32'h00000002);
    wr(OFF_EXEC_STAT, 32'h00000002, 1'b0);
    rdc("exec_stat", OFF_EXEC_STAT, 32'h00000000);
    finish_test();
  end
endmodule
